// File: pkg/afp_pkg.sv
// afp_pkg: constants and carrier types for the amplifier fault-protection sequencer
// assumes a 40 MHz sys_clk and comparator flags from the analog sensors
package afp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int RESTART_MS = 100;
    localparam int DIAG_MIN_MS = 100;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int MS_CNT_W = 16;
    localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);
    localparam int MS_W = 8;
    localparam logic [MS_W-1:0] RESTART_MS_CNT = MS_W'(RESTART_MS);
    localparam logic [MS_W-1:0] DIAG_MS_CNT = MS_W'(DIAG_MIN_MS);
    localparam logic [MS_W-1:0] MS_ZERO = 8'h00;
    localparam logic [MS_W-1:0] MS_ONE = 8'h01;

    // ------------------------------------------------------------
    // gain foldback and integrator
    // ------------------------------------------------------------
    localparam int GAIN_W = 4;
    // gain attenuation in 1 dB steps; full step count reached before shutdown
    localparam logic [GAIN_W-1:0] GAIN_ATT_NONE = 4'h0;
    localparam logic [GAIN_W-1:0] GAIN_ATT_MAX = 4'h6;
    localparam int INTEG_W = 8;
    localparam logic [INTEG_W-1:0] INTEG_DEPTH_DEF = 8'h20;
    localparam logic [INTEG_W-1:0] INTEG_ZERO = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic warn_hi;      // at or above warning_temp
        logic warn_lo;      // below warning_release_temp
        logic fold_hi;      // above foldback_start_temp
        logic shut_hi;      // at or above shutdown_temp
    } afp_temp_t;

    typedef struct packed {
        logic oc_hi;        // high-side switch over current_limit_level
        logic oc_lo;        // low-side switch over current_limit_level
        logic low_z;        // short below short_impedance_limit
    } afp_oc_t;

    typedef enum {
        AFP_STANDBY,
        AFP_WINDOW,
        AFP_RUN,
        AFP_OC_OFF,
        AFP_OT_OFF
    } afp_state_t;
endpackage

// File: verilog/afp_ctrl.sv
// afp_ctrl: thermal foldback, overtemperature, overcurrent and window protection
// assumes comparator flags are asynchronous; pwm_cycle is a one-cycle pulse per switching period
`timescale 1ns/1ps
module afp_ctrl
    import afp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pwm_cycle,
    input wire logic pwm_hs_in,
    input wire logic amp_enable,
    input wire logic foldback_disable,
    input wire afp_temp_t temp_flags,
    input wire afp_oc_t oc_flags,
    input wire logic out_short_supply,
    input wire logic [INTEG_W-1:0] integ_depth,
    output logic switching_en,
    output logic pwm_hs,
    output logic pwm_ls,
    output logic [GAIN_W-1:0] gain_atten,
    output logic [INTEG_W-1:0] integ_level,
    output logic thermal_warn_n_o,
    output logic thermal_warn_n_oe,
    output logic fault_diag_n_o,
    output logic fault_diag_n_oe
);

    // ------------------------------------------------------------
    // input synchronisers: three stages, change once 2nd and 3rd agree
    // ------------------------------------------------------------
    localparam int SYNC_W = 9;
    // window input resets to short present: no start before the
    // three-stage pipe has seen the real pin
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h002;
    logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
    logic [SYNC_W-1:0] raw_in;
    assign raw_in = {temp_flags, oc_flags, out_short_supply, foldback_disable};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
            s3_reg <= SYNC_RST;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flt_reg <= SYNC_RST;
        end else begin
            for (int i = 0; i < SYNC_W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    flt_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    afp_temp_t t_s;
    afp_oc_t oc_s;
    logic short_s, fb_dis_s;
    assign {t_s, oc_s, short_s, fb_dis_s} = flt_reg;

    // ------------------------------------------------------------
    // millisecond timebase
    // ------------------------------------------------------------
    logic [MS_CNT_W-1:0] ms_div_reg;
    logic ms_tick;
    assign ms_tick = (ms_div_reg == MS_LAST);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ms_div_reg <= '0;
        end else if (ms_tick) begin
            ms_div_reg <= '0;
        end else begin
            ms_div_reg <= ms_div_reg + 1'b1;
        end
    end

    function automatic logic [MS_W-1:0] ms_dec(input logic [MS_W-1:0] v);
        ms_dec = (v == MS_ZERO) ? MS_ZERO : v - MS_ONE;
    endfunction

    // ------------------------------------------------------------
    // thermal warning with hysteresis
    // ------------------------------------------------------------
    logic warn_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            warn_reg <= 1'b0;
        end else if (t_s.warn_hi) begin
            warn_reg <= 1'b1;
        end else if (t_s.warn_lo) begin
            warn_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // gain foldback: one step per ms while in foldback band
    // ------------------------------------------------------------
    logic [GAIN_W-1:0] gain_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gain_reg <= GAIN_ATT_NONE;
        end else if (fb_dis_s) begin
            gain_reg <= GAIN_ATT_NONE;
        end else if (ms_tick) begin
            if (t_s.fold_hi && gain_reg != GAIN_ATT_MAX) begin
                gain_reg <= gain_reg + 1'b1;
            end else if (!t_s.fold_hi && gain_reg != GAIN_ATT_NONE) begin
                gain_reg <= gain_reg - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    afp_state_t state_reg;
    logic [MS_W-1:0] tmr_reg;
    logic [INTEG_W-1:0] integ_reg;
    logic oc_any, running, oc_trip;
    assign oc_any = oc_s.oc_hi | oc_s.oc_lo;
    assign running = (state_reg == AFP_RUN);
    // overcurrent seen on a low-impedance short
    function automatic logic low_z_event(input afp_oc_t f);
        low_z_event = (f.oc_hi | f.oc_lo) & f.low_z;
    endfunction

    assign oc_trip = running && pwm_cycle && low_z_event(oc_s);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            integ_reg <= INTEG_DEPTH_DEF;
        end else if (!running) begin
            integ_reg <= integ_depth;
        end else if (pwm_cycle) begin
            if (low_z_event(oc_s)) begin
                if (integ_reg != INTEG_ZERO) begin
                    integ_reg <= integ_reg - 1'b1;
                end
            end else if (integ_reg < integ_depth) begin
                integ_reg <= integ_reg + 1'b1;
            end
        end
    end

    logic depleted;
    assign depleted = oc_trip && (integ_reg <= INTEG_W'(1));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= AFP_STANDBY;
            tmr_reg <= MS_ZERO;
        end else begin
            if (ms_tick) begin
                tmr_reg <= ms_dec(tmr_reg);
            end
            case (state_reg)
                AFP_STANDBY: begin
                    if (amp_enable) begin
                        state_reg <= AFP_WINDOW;
                    end
                end
                AFP_WINDOW: begin
                    // hold until short clears, then start directly
                    if (!amp_enable) begin
                        state_reg <= AFP_STANDBY;
                    end else if (t_s.shut_hi) begin
                        state_reg <= AFP_OT_OFF;
                        tmr_reg <= RESTART_MS_CNT;
                    end else if (!short_s) begin
                        state_reg <= AFP_RUN;
                    end
                end
                AFP_RUN: begin
                    if (!amp_enable) begin
                        state_reg <= AFP_STANDBY;
                    end else if (t_s.shut_hi) begin
                        state_reg <= AFP_OT_OFF;
                        tmr_reg <= RESTART_MS_CNT;
                    end else if (depleted) begin
                        state_reg <= AFP_OC_OFF;
                        tmr_reg <= RESTART_MS_CNT;
                    end
                end
                AFP_OC_OFF: begin
                    // retry every 100 ms via window check
                    if (!amp_enable) begin
                        state_reg <= AFP_STANDBY;
                    end else if (tmr_reg == MS_ZERO) begin
                        state_reg <= AFP_WINDOW;
                    end
                end
                AFP_OT_OFF: begin
                    // restart timer runs only while cool
                    if (!amp_enable) begin
                        state_reg <= AFP_STANDBY;
                    end else if (t_s.shut_hi) begin
                        tmr_reg <= RESTART_MS_CNT;
                    end else if (tmr_reg == MS_ZERO) begin
                        state_reg <= AFP_WINDOW;
                    end
                end
                default: begin
                    state_reg <= AFP_STANDBY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power switch drive
    // ------------------------------------------------------------
    logic hs_reg, ls_reg, lim_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
        end else if (!running) begin
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
        // turn off faulty switch, turn on complement
        end else if (oc_s.oc_hi) begin
            hs_reg <= 1'b0;
            ls_reg <= 1'b1;
        end else if (oc_s.oc_lo) begin
            hs_reg <= 1'b1;
            ls_reg <= 1'b0;
        end else begin
            hs_reg <= pwm_hs_in;
            ls_reg <= !pwm_hs_in;
        end
    end

    // limiting flag follows switching cycle: set on event, cleared at next cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lim_reg <= 1'b0;
        end else if (!running) begin
            lim_reg <= 1'b0;
        end else if (oc_any) begin
            lim_reg <= 1'b1;
        end else if (pwm_cycle) begin
            lim_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // fault diagnostic
    // ------------------------------------------------------------
    logic [MS_W-1:0] diag_tmr_reg;
    logic run_d_reg, diag_reg, pulse_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_d_reg <= 1'b0;
            diag_tmr_reg <= MS_ZERO;
        end else begin
            run_d_reg <= running;
            // minimum width after any protective stop
            if (run_d_reg && !running) begin
                diag_tmr_reg <= DIAG_MS_CNT;
            end else if (ms_tick) begin
                diag_tmr_reg <= ms_dec(diag_tmr_reg);
            end
        end
    end

    // toggle at switching rate while limiting
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulse_reg <= 1'b0;
        end else if (!lim_reg) begin
            pulse_reg <= 1'b0;
        end else if (pwm_cycle) begin
            pulse_reg <= 1'b1;
        end else if (!pwm_hs_in) begin
            pulse_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_reg <= 1'b1;
        end else begin
            diag_reg <= !running || (diag_tmr_reg != MS_ZERO) || pulse_reg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign switching_en = running;
    // drives gated by the run state: off in the very cycle
    // the sequencer leaves run, not one edge later
    assign pwm_hs = hs_reg && running;
    assign pwm_ls = ls_reg && running;
    assign gain_atten = gain_reg;
    assign integ_level = integ_reg;
    // open drain: oe low pulls pin low
    assign thermal_warn_n_o = 1'b0;
    assign thermal_warn_n_oe = !warn_reg;
    assign fault_diag_n_o = 1'b0;
    assign fault_diag_n_oe = !diag_reg;
endmodule

// File: dv/afp_ctrl_properties.sv
// afp_ctrl_properties: concurrent checks on the fault-protection sequencer ports
// assumes one sys_clk domain and the async active-high rst
`timescale 1ns/1ps
module afp_ctrl_properties
    import afp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic foldback_disable,
    input wire afp_temp_t temp_flags,
    input wire logic out_short_supply,
    input wire logic [INTEG_W-1:0] integ_depth,
    input wire logic switching_en,
    input wire logic pwm_hs,
    input wire logic pwm_ls,
    input wire logic [GAIN_W-1:0] gain_atten,
    input wire logic [INTEG_W-1:0] integ_level,
    input wire logic thermal_warn_n_o,
    input wire logic fault_diag_n_o,
    input wire logic fault_diag_n_oe,
    input wire logic thermal_warn_n_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_PWM_OFF: assert property (!switching_en |-> !pwm_hs && !pwm_ls)
        else $error("switch drive while not running");
    AST_NOT_BOTH: assert property (!(pwm_hs && pwm_ls))
        else $error("both switches on");
    AST_GAIN_MAX: assert property (gain_atten <= GAIN_ATT_MAX)
        else $error("attenuation above limit");
    AST_OPEN_DRAIN: assert property (!thermal_warn_n_o && !fault_diag_n_o)
        else $error("diagnostic output driven high");
    AST_FAULT_STOP: assert property ($fell(switching_en) |-> ##[0:2] !fault_diag_n_oe)
        else $error("fault pin not asserted at shutdown");
    AST_NO_FOLD: assert property (foldback_disable [*8] |=> gain_atten <= $past(gain_atten))
        else $error("gain reduced with foldback disabled");
    AST_INTEG_SAT: assert property (switching_en |-> integ_level <= integ_depth)
        else $error("integrator above depth");
    AST_INTEG_STEP: assert property (switching_en && $past(switching_en) && integ_level != $past(integ_level)
        |-> integ_level + 8'h01 == $past(integ_level) || integ_level == $past(integ_level) + 8'h01)
        else $error("integrator moved by more than one");
    AST_WARN_HOLD: assert property (!temp_flags.warn_lo [*5] ##0 !thermal_warn_n_oe |=> !thermal_warn_n_oe)
        else $error("warning released above release level");
    AST_SHUT: assert property (temp_flags.shut_hi [*8] |=> !switching_en)
        else $error("switching at shutdown temperature");
    AST_WINDOW: assert property ((!switching_en && out_short_supply) [*6] |=> !switching_en)
        else $error("start with output shorted to supply");
endmodule

bind afp_ctrl afp_ctrl_properties i_props (.sys_clk(sys_clk), .rst(rst), .foldback_disable(foldback_disable),
    .temp_flags(temp_flags), .out_short_supply(out_short_supply), .integ_depth(integ_depth),
    .switching_en(switching_en), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls), .gain_atten(gain_atten),
    .integ_level(integ_level), .thermal_warn_n_o(thermal_warn_n_o), .fault_diag_n_o(fault_diag_n_o),
    .fault_diag_n_oe(fault_diag_n_oe), .thermal_warn_n_oe(thermal_warn_n_oe));

// File: dv/afp_host_model.sv
// afp_host_model: host side of the two open-drain diagnostic pins
// assumes external pull-ups; oe low means the device pulls the pin low
`timescale 1ns/1ps
module afp_host_model (
    input wire logic thermal_warn_n_o,
    input wire logic thermal_warn_n_oe,
    input wire logic fault_diag_n_o,
    input wire logic fault_diag_n_oe,
    output logic warn_pin_n,
    output logic fault_pin_n
);
    assign warn_pin_n = thermal_warn_n_oe ? 1'b1 : thermal_warn_n_o;
    assign fault_pin_n = fault_diag_n_oe ? 1'b1 : fault_diag_n_o;
endmodule

// File: dv/amp_fault_protection_control_bench.sv
// amp_fault_protection_control_bench: directed test of the fault-protection sequencer
// assumes afp_pkg, the bound checker and the host pull-up model
`timescale 1ns/1ps
module amp_fault_protection_control_bench;
    import afp_pkg::*;
    logic sys_clk = 0, rst = 1, pwm_cycle = 0, pwm_hs_in = 0, amp_enable = 0, foldback_disable = 0;
    logic out_short_supply = 1;
    afp_temp_t temp_flags = 4'b0100;
    afp_oc_t oc_flags = 3'b000;
    logic [INTEG_W-1:0] integ_depth = 8'h04;
    logic switching_en, pwm_hs, pwm_ls, tw_o, tw_oe, fd_o, fd_oe, warn_pin_n, fault_pin_n;
    logic [GAIN_W-1:0] gain_atten;
    logic [INTEG_W-1:0] integ_level;
    int n_errors = 0, check_count = 0;

    afp_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .pwm_cycle(pwm_cycle), .pwm_hs_in(pwm_hs_in),
        .amp_enable(amp_enable), .foldback_disable(foldback_disable), .temp_flags(temp_flags),
        .oc_flags(oc_flags), .out_short_supply(out_short_supply), .integ_depth(integ_depth),
        .switching_en(switching_en), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls), .gain_atten(gain_atten),
        .integ_level(integ_level), .thermal_warn_n_o(tw_o), .thermal_warn_n_oe(tw_oe),
        .fault_diag_n_o(fd_o), .fault_diag_n_oe(fd_oe));
    afp_host_model i_host (.thermal_warn_n_o(tw_o), .thermal_warn_n_oe(tw_oe), .fault_diag_n_o(fd_o),
        .fault_diag_n_oe(fd_oe), .warn_pin_n(warn_pin_n), .fault_pin_n(fault_pin_n));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t mismatch got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_en(input logic v);
        int i;
        for (i = 0; i < 60 && switching_en !== v; i++) step(1);
        check(switching_en, v);
    endtask
    task automatic wait_gain(input logic [GAIN_W-1:0] v, input int limit);
        int i;
        for (i = 0; i < limit && gain_atten !== v; i++) step(1);
        check(gain_atten, v);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            step(1);
            pwm_cycle = 1;
            step(1);
            pwm_cycle = 0;
            step(2);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        step(12);
        check({switching_en, gain_atten, warn_pin_n, fault_pin_n}, 7'b0_0000_10); // reset state
        check(integ_level, 8'h20); // reset depth
        rst = 0;
        amp_enable = 1;
        step(20);
        check({switching_en, fault_pin_n}, 2'b00); // start held
        out_short_supply = 0;
        wait_en(1); // start resumes
        step(4);
        check(fault_pin_n, 1'b1); // released once switching
        check(integ_level, 8'h04); // reload
        foldback_disable = 1;
        temp_flags = 4'b1000;
        step(8);
        check({warn_pin_n, gain_atten}, 5'h00); // warning with foldback off
        temp_flags = 4'b0000;
        step(8);
        check(warn_pin_n, 1'b0); // hysteresis hold
        foldback_disable = 0;
        temp_flags = 4'b0010;
        wait_gain(4'h1, 40100); // first foldback step within one ms
        check(warn_pin_n, 1'b0); // still held in foldback band
        foldback_disable = 1;
        step(8);
        check(gain_atten, 4'h0); // foldback cleared by mode input
        temp_flags = 4'b0100;
        step(8);
        check(warn_pin_n, 1'b1); // release
        pwm_hs_in = 1;
        oc_flags = 3'b100;
        step(8);
        check({pwm_hs, pwm_ls, switching_en}, 3'b011); // swap, keep running
        oc_flags = 3'b000;
        pulse(1);
        step(2);
        check({pwm_hs, pwm_ls}, 2'b10); // resume once oc flag clears
        check(fault_pin_n, 1'b0); // pulse while limiting
        oc_flags = 3'b101;
        step(8);
        pulse(2);
        check(integ_level, 8'h02); // deplete
        oc_flags = 3'b000;
        step(8);
        pulse(1);
        check(integ_level, 8'h03); // recover
        oc_flags = 3'b101;
        step(8);
        pulse(3);
        wait_en(0); // depletion shutdown
        step(3);
        check({pwm_hs, pwm_ls, fault_pin_n}, 3'b000); // off, fault held
        step(200);
        check({switching_en, fault_pin_n}, 2'b00); // no early retry
        oc_flags = 3'b000;
        rst = 1;
        step(2);
        rst = 0;
        wait_en(1); // clean start
        temp_flags = 4'b1111;
        wait_en(0); // overtemperature stop
        step(3);
        check({pwm_hs, pwm_ls, fault_pin_n}, 3'b000); // off and flagged
        conclude();
    end

    initial begin
        #(50000 * 25);
        n_errors++;
        conclude();
    end
endmodule
